// file: logic/wtb_pkg.sv
// wtb_pkg: constants, field layouts and types of the watchdog timer block.
// assumes a 40 MHz system clock and a 32 kHz low-power rc oscillator.
`default_nettype none
package wtb_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ        = 40_000_000;
	localparam int OSC_HZ        = 32_000;
	localparam int OSC_CYCLES    = CLK_HZ / OSC_HZ;
	localparam int BASE_SHORT_US = 1000;
	localparam int BASE_LONG_US  = 4000;
	localparam int PRE_DIV_SHORT = BASE_SHORT_US * OSC_HZ / 1_000_000;
	localparam int PRE_DIV_LONG  = BASE_LONG_US * OSC_HZ / 1_000_000;
	localparam logic [6:0] PRE_LAST_SHORT = 7'(PRE_DIV_SHORT - 1);
	localparam logic [6:0] PRE_LAST_LONG  = 7'(PRE_DIV_LONG - 1);

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [31:0] ADDR_CONFIG = 32'h0000_0000;
	localparam logic [31:0] ADDR_RST_CTRL = 32'h0000_0004;
	localparam logic [31:0] ADDR_STATE  = 32'h0000_0008;

	// ------------------------------------------------------------
	// field layouts
	// ------------------------------------------------------------
	typedef struct packed {
		logic       always_on;
		logic       window_disable;
		logic       reserved;
		logic       prescale_select;
		logic [3:0] postscale_select;
	} wtb_cfg_type;

	typedef struct packed {
		logic [1:0] reserved_hi;
		logic       software_enable;
		logic       timeout_flag;
		logic       sleep_flag;
		logic       idle_flag;
		logic [1:0] reserved_lo;
	} wtb_rst_ctrl_type;

	typedef enum logic [1:0] {
		MODE_RUN   = 2'b00,
		MODE_SLEEP = 2'b01,
		MODE_IDLE  = 2'b11
	} wtb_mode_type;

	localparam wtb_cfg_type  CFG_RESET  = 8'hdf;
	localparam wtb_rst_ctrl_type RST_CTRL_RESET = 8'h00;

endpackage
`default_nettype wire

// file: logic/wtb_low_power_rc_osc_osc.sv
// wtb_rc_osc: low-power rc oscillator stand-in, one tick per oscillator period.
// assumes the system clock runs at CLK_HZ; ticks only while enabled.
`timescale 1ns/1ps
`default_nettype none
module wtb_rc_osc
	import wtb_pkg::*;
#(
	parameter int CYCLES = OSC_CYCLES
) (
	input  wire logic clk_in,
	input  wire logic srst_in,
	input  wire logic enable_in,
	output var  logic tick_out
);

	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic        tick_d;

	// ------------------------------------------------------------
	// divider
	// ------------------------------------------------------------
	always_comb begin
		cnt_d  = cnt_q + 16'h0001;
		tick_d = 1'b0;
		if (!enable_in) begin
			cnt_d = 16'h0000;
		end else if (cnt_q == 16'(CYCLES - 1)) begin
			cnt_d  = 16'h0000;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cnt_q    <= 16'h0000;
			tick_out <= 1'b0;
		end else begin
			cnt_q    <= cnt_d;
			tick_out <= tick_d;
		end
	end

endmodule
`default_nettype wire

// file: logic/wtb_watchdog.sv
// wtb_watchdog: watchdog timer with prescaler, postscaler and window mode.
// assumes one ahb-lite master, zero-wait slave; cpu events arrive as one-cycle pulses.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module wtb_watchdog
	import wtb_pkg::*;
#(
	parameter int OSC_DIV = OSC_CYCLES
) (
	input  wire logic        CLOCK_IN,
	input  wire logic        SRST_IN,
	input  wire logic        HSEL_IN,
	input  wire logic [31:0] HADDR_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HWRITE_IN,
	input  wire logic [2:0]  HSIZE_IN,
	input  wire logic [31:0] HWDATA_IN,
	input  wire logic        HREADY_IN,
	output var  logic [31:0] HRDATA_OUT,
	output var  logic        HREADYOUT_OUT,
	output var  logic        HRESP_OUT,
	input  wire logic        WDOG_CLEAR_IN,
	input  wire logic        SLEEP_CMD_IN,
	input  wire logic        IDLE_CMD_IN,
	input  wire logic        WAKE_IN,
	input  wire logic        CLK_SWITCH_DONE_IN,
	output var  logic        WDT_RESET_OUT,
	output var  logic        WAKE_OUT,
	output var  logic        OSC_ON_OUT
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [14:0] post_last(input logic [3:0] code);
		post_last = (15'h0001 << code) - 15'h0001;
	endfunction

	function automatic logic [25:0] elapsed4(input logic [6:0] pre, input logic [14:0] post,
			input logic long_div);
		logic [23:0] e;
		e = long_div ? ({2'b00, post, 7'h00} + {17'h00000, pre})
			: ({4'h0, post, 5'h00} + {17'h00000, pre});
		elapsed4 = {e, 2'b00};
	endfunction

	function automatic logic [25:0] period3(input logic long_div, input logic [3:0] code);
		logic [23:0] p;
		p = (long_div ? 24'(PRE_DIV_LONG) : 24'(PRE_DIV_SHORT)) << code;
		period3 = {2'b00, p} + {1'b0, p, 1'b0};
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	wtb_cfg_type  cfg_q,  cfg_d;
	wtb_rst_ctrl_type rstctl_q, rstctl_d;
	wtb_mode_type mode_q, mode_d;
	logic [6:0]   pre_q,  pre_d;
	logic [14:0]  post_q, post_d;
	logic         reset_d, wake_d, osc_on_d;
	logic         wr_cfg_q, wr_cfg_d, wr_rstctl_q, wr_rstctl_d;
	logic [31:0]  hrdata_d;

	logic         enable;
	logic         osc_tick;
	logic         pre_end;
	logic         timeout;
	logic         clr_run;
	logic         early;
	logic         enter_sleep;
	logic         enter_idle;
	logic         exit_save;
	logic         clear_counts;
	logic         dev_reset;
	logic         addr_phase;

	// ------------------------------------------------------------
	// oscillator
	// ------------------------------------------------------------
	assign enable = cfg_q.always_on | rstctl_q.software_enable;

	wtb_rc_osc #(
		.CYCLES    (OSC_DIV)
	) u_osc (
		.clk_in    (CLOCK_IN),
		.srst_in   (SRST_IN),
		.enable_in (enable),
		.tick_out  (osc_tick)
	);

	// ------------------------------------------------------------
	// events
	// ------------------------------------------------------------
	always_comb begin
		pre_end = osc_tick & (pre_q == (cfg_q.prescale_select ? PRE_LAST_LONG : PRE_LAST_SHORT));
		timeout = enable & pre_end & (post_q == post_last(cfg_q.postscale_select));
		clr_run = WDOG_CLEAR_IN & (mode_q == MODE_RUN);
		early   = !cfg_q.window_disable & (elapsed4(pre_q, post_q, cfg_q.prescale_select) <
			period3(cfg_q.prescale_select, cfg_q.postscale_select));
		enter_sleep = SLEEP_CMD_IN & (mode_q == MODE_RUN);
		enter_idle  = IDLE_CMD_IN & !SLEEP_CMD_IN & (mode_q == MODE_RUN);
		exit_save   = (mode_q != MODE_RUN) & (WAKE_IN | timeout);
		dev_reset   = (timeout & (mode_q == MODE_RUN)) | (clr_run & enable & early);
		clear_counts = !enable | CLK_SWITCH_DONE_IN | enter_sleep | enter_idle | exit_save
			| clr_run | dev_reset;
	end

	// ------------------------------------------------------------
	// counters and mode
	// ------------------------------------------------------------
	always_comb begin
		pre_d   = pre_q;
		post_d  = post_q;
		mode_d  = mode_q;
		reset_d = dev_reset;
		wake_d  = timeout & (mode_q != MODE_RUN);
		osc_on_d = enable;
		if (osc_tick) begin
			if (pre_end) begin
				pre_d  = 7'h00;
				post_d = timeout ? 15'h0000 : post_q + 15'h0001;
			end else begin
				pre_d = pre_q + 7'h01;
			end
		end
		case (mode_q)
			MODE_RUN: begin
				if (enter_sleep) begin
					mode_d = MODE_SLEEP;
				end else if (enter_idle) begin
					mode_d = MODE_IDLE;
				end
			end
			MODE_SLEEP, MODE_IDLE: begin
				if (exit_save) begin
					mode_d = MODE_RUN;
				end
			end
			default: begin
				mode_d = MODE_RUN;
			end
		endcase
		if (clear_counts) begin
			pre_d  = 7'h00;
			post_d = 15'h0000;
		end
		if (dev_reset) begin
			mode_d = MODE_RUN;
		end
	end

	// ------------------------------------------------------------
	// registers and bus
	// ------------------------------------------------------------
	assign addr_phase = HSEL_IN & HTRANS_IN[1] & HREADY_IN;

	always_comb begin
		cfg_d     = cfg_q;
		rstctl_d    = rstctl_q;
		wr_cfg_d    = addr_phase & HWRITE_IN & (HADDR_IN == ADDR_CONFIG);
		wr_rstctl_d = addr_phase & HWRITE_IN & (HADDR_IN == ADDR_RST_CTRL);
		if (wr_cfg_q) begin
			cfg_d = wtb_cfg_type'(HWDATA_IN[7:0] & 8'hdf);
		end
		if (wr_rstctl_q) begin
			rstctl_d.software_enable = HWDATA_IN[5];
			rstctl_d.timeout_flag    = HWDATA_IN[4];
			rstctl_d.sleep_flag      = HWDATA_IN[3];
			rstctl_d.idle_flag       = HWDATA_IN[2];
		end
		if (timeout | dev_reset) begin
			rstctl_d.timeout_flag = 1'b1;
		end
		if (enter_sleep) begin
			rstctl_d.sleep_flag = 1'b1;
		end
		if (enter_idle) begin
			rstctl_d.idle_flag = 1'b1;
		end
		if (dev_reset) begin
			rstctl_d.software_enable = 1'b0;
		end
		hrdata_d = 32'h0000_0000;
		if (addr_phase & !HWRITE_IN) begin
			case (HADDR_IN)
				ADDR_CONFIG: hrdata_d = {24'h000000, cfg_d};
				ADDR_RST_CTRL: hrdata_d = {24'h000000, rstctl_d};
				ADDR_STATE:  hrdata_d = {8'h00, mode_d, post_d, pre_d};
				default:     hrdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLOCK_IN) begin
		if (SRST_IN) begin
			cfg_q         <= CFG_RESET;
			rstctl_q      <= RST_CTRL_RESET;
			mode_q        <= MODE_RUN;
			pre_q         <= 7'h00;
			post_q        <= 15'h0000;
			wr_cfg_q      <= 1'b0;
			wr_rstctl_q   <= 1'b0;
			HRDATA_OUT    <= 32'h0000_0000;
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT     <= 1'b0;
			WDT_RESET_OUT <= 1'b0;
			WAKE_OUT      <= 1'b0;
			OSC_ON_OUT    <= 1'b0;
		end else begin
			cfg_q         <= cfg_d;
			rstctl_q      <= rstctl_d;
			mode_q        <= mode_d;
			pre_q         <= pre_d;
			post_q        <= post_d;
			wr_cfg_q      <= wr_cfg_d;
			wr_rstctl_q   <= wr_rstctl_d;
			HRDATA_OUT    <= hrdata_d;
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT     <= 1'b0;
			WDT_RESET_OUT <= reset_d;
			WAKE_OUT      <= wake_d;
			OSC_ON_OUT    <= osc_on_d;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (SRST_IN);

	sequence s_enter_sleep;
		mode_q == MODE_RUN && SLEEP_CMD_IN && !dev_reset;
	endsequence

	sequence s_sleep_settled;
		mode_q == MODE_SLEEP && pre_q == 7'h00 && post_q == 15'h0000 && rstctl_q.sleep_flag;
	endsequence

	sequence s_run_timeout;
		timeout && mode_q == MODE_RUN;
	endsequence

	a_run_timeout_reset:
	assert property (s_run_timeout |=> WDT_RESET_OUT && rstctl_q.timeout_flag && !rstctl_q.software_enable)
		else $error("running timeout did not reset");

	a_save_timeout_wake:
	assert property (timeout && mode_q != MODE_RUN |=> WAKE_OUT && !WDT_RESET_OUT && mode_q == MODE_RUN)
		else $error("timeout in power save did not wake");

	a_flag_sticky_hold:
	assert property (rstctl_q.timeout_flag && !wr_rstctl_q |=> rstctl_q.timeout_flag)
		else $error("timeout flag dropped by itself");

	a_sleep_entry_clear:
	assert property (s_enter_sleep |=> s_sleep_settled)
		else $error("sleep entry did not clear counts");

	a_clear_inst_counts:
	assert property (clr_run && !dev_reset |=> pre_q == 7'h00 && post_q == 15'h0000 && !WDT_RESET_OUT)
		else $error("clear instruction did not clear counts");

	a_window_early_reset:
	assert property (clr_run && enable && !cfg_q.window_disable && post_q == 15'h0000
		&& pre_q < 7'h18 |=> WDT_RESET_OUT)
		else $error("early clear in window mode did not reset");

	a_always_on_osc:
	assert property (cfg_q.always_on [*2] |-> OSC_ON_OUT)
		else $error("always-on watchdog oscillator is off");

	a_disabled_held:
	assert property (!enable [*2] |-> pre_q == 7'h00 && post_q == 15'h0000 && !OSC_ON_OUT)
		else $error("disabled watchdog is counting");

	a_prescale_wrap:
	assert property (osc_tick && enable && !clear_counts && pre_q == 7'h1f && !cfg_q.prescale_select
		|=> pre_q == 7'h00 && post_q == $past(post_q) + 15'h0001 || $past(timeout))
		else $error("short prescaler did not wrap at 32");

	a_swen_cleared:
	assert property ($fell(SRST_IN) |-> !rstctl_q.software_enable)
		else $error("reset left software enable set");

endmodule
`default_nettype wire

// file: verification/test_watchdog_timer_block.sv
// test_watchdog_timer_block: self-checking bench of the watchdog timer block.
// assumes wtb_pkg and wtb_watchdog are compiled first; the bench is bus master and cpu.
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_timer_block
	import wtb_pkg::*;
#(
	parameter int DIV = 2
);
	logic              clk;
	logic              srst;
	logic              hsel;
	logic              hwrite;
	logic [1:0]        htrans;
	logic [31:0]       haddr;
	logic [31:0]       hwdata;
	logic [4:0]        ev;
	wire  logic [31:0] hrdata;
	wire  logic        ready;
	wire  logic        hresp;
	wire  logic        wdt_rst;
	wire  logic        wake;
	wire  logic        osc_on;
	int                error_cnt = 0;
	int                checked = 0;

	// ev: 0 clear, 1 sleep, 2 idle, 3 wake, 4 clock switch done
	wtb_watchdog #(.OSC_DIV(DIV)) wtb_watchdog_i (
		.CLOCK_IN          (clk),
		.SRST_IN           (srst),
		.HSEL_IN           (hsel),
		.HADDR_IN          (haddr),
		.HTRANS_IN         (htrans),
		.HWRITE_IN         (hwrite),
		.HSIZE_IN          (3'h2),
		.HWDATA_IN         (hwdata),
		.HREADY_IN         (ready),
		.HRDATA_OUT        (hrdata),
		.HREADYOUT_OUT     (ready),
		.HRESP_OUT         (hresp),
		.WDOG_CLEAR_IN     (ev[0]),
		.SLEEP_CMD_IN      (ev[1]),
		.IDLE_CMD_IN       (ev[2]),
		.WAKE_IN           (ev[3]),
		.CLK_SWITCH_DONE_IN(ev[4]),
		.WDT_RESET_OUT     (wdt_rst),
		.WAKE_OUT          (wake),
		.OSC_ON_OUT        (osc_on)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask

	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (ready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (ready !== 1'b1);
		q = hrdata;
	endtask

	// the event is taken at the edge on which this task returns
	task automatic pulse(input logic [4:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 5'h00;
	endtask

	// waits for the next timeout and judges its moment and its kind
	task automatic expire(input int ticks, input logic slept);
		int n;
		n = 0;
		while (wdt_rst !== 1'b1 && wake !== 1'b1 && n < ticks * DIV * 2 + 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(n >= (ticks - 1) * DIV && n <= (ticks + 1) * DIV + 4, "timeout moment");
		chk(wake === slept && wdt_rst === !slept, "timeout kind");
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] q;
		xfer(1'b0, ADDR_CONFIG, 32'h0, q);
		chk(q === {24'h0, CFG_RESET}, "config reset value");
		xfer(1'b0, ADDR_RST_CTRL, 32'h0, q);
		chk(q === 32'h0 && hresp === 1'b0, "reset control reset value");
		chk(osc_on === 1'b1, "oscillator off");
		xfer(1'b1, 32'h10, 32'hff, q);
		xfer(1'b0, 32'h10, 32'h0, q);
		chk(q === 32'h0, "unmapped read");
	endtask

	task automatic t_scale();
		logic [31:0] q;
		logic [7:0] cf [5];
		int tk [5];
		cf = '{8'hc0, 8'hc1, 8'hc2, 8'hd0, 8'hd1};
		tk = '{32, 64, 128, 128, 256};
		for (int i = 0; i < 5; i++) begin
			xfer(1'b1, ADDR_CONFIG, {24'h0, cf[i]}, q);
			repeat (10 * DIV) @(posedge clk);
			pulse(i[0] ? 5'h10 : 5'h01);
			expire(tk[i], 1'b0);
		end
	endtask

	task automatic t_flag();
		logic [31:0] q;
		xfer(1'b0, ADDR_RST_CTRL, 32'h0, q);
		chk(q[4] === 1'b1, "timeout flag not set");
		repeat (20) @(posedge clk);
		xfer(1'b0, ADDR_RST_CTRL, 32'h0, q);
		chk(q[4] === 1'b1, "timeout flag not sticky");
		xfer(1'b1, ADDR_RST_CTRL, 32'h0, q);
		xfer(1'b0, ADDR_RST_CTRL, 32'h0, q);
		chk(q[4] === 1'b0, "timeout flag not cleared");
	endtask

	task automatic t_sleep();
		logic [31:0] q;
		xfer(1'b1, ADDR_CONFIG, 32'hc0, q);
		pulse(5'h02);
		expire(32, 1'b1);
		xfer(1'b0, ADDR_RST_CTRL, 32'h0, q);
		chk(q[4:3] === 2'b11, "sleep wake flags");
		xfer(1'b1, ADDR_RST_CTRL, 32'h0, q);
		xfer(1'b0, ADDR_RST_CTRL, 32'h0, q);
		chk(q === 32'h0, "flags not cleared");
		pulse(5'h04);
		repeat (20 * DIV) @(posedge clk);
		pulse(5'h08);
		expire(32, 1'b0);
	endtask

	task automatic t_window();
		logic [31:0] q;
		xfer(1'b1, ADDR_CONFIG, 32'h80, q);
		pulse(5'h10);
		pulse(5'h01);
		#1;
		chk(wdt_rst === 1'b1, "early clear kept");
		repeat (27 * DIV) @(posedge clk);
		pulse(5'h01);
		#1;
		chk(wdt_rst === 1'b0, "late clear refused");
		expire(32, 1'b0);
	endtask

	task automatic t_soft();
		logic [31:0] q;
		logic hit;
		hit = 1'b0;
		xfer(1'b1, ADDR_CONFIG, 32'h40, q);
		xfer(1'b1, ADDR_RST_CTRL, 32'h0, q);
		pulse(5'h10);
		for (int i = 0; i < 40 * DIV; i++) begin
			@(posedge clk);
			#1;
			hit = hit | (wdt_rst === 1'b1);
		end
		chk(osc_on === 1'b0 && hit === 1'b0, "runs while disabled");
		xfer(1'b1, ADDR_RST_CTRL, 32'h20, q);
		pulse(5'h10);
		chk(osc_on === 1'b1, "oscillator not forced on");
		expire(32, 1'b0);
		xfer(1'b1, ADDR_RST_CTRL, 32'h20, q);
		repeat (10) @(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		xfer(1'b0, ADDR_RST_CTRL, 32'h0, q);
		chk(q === 32'h0, "software enable survives reset");
		xfer(1'b0, ADDR_STATE, 32'h0, q);
		chk(q[21:2] === 20'h0, "counts survive reset");
	endtask

	// ------------------------------------------------------------
	// run
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		#500us;
		error_cnt++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end

	initial begin
		srst = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwdata = 32'h0;
		ev = 5'h00;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_scale();
		t_flag();
		t_sleep();
		t_window();
		t_soft();
		stop_test();
	end
endmodule
`default_nettype wire
